/* rtl/rcr_reset_cause_recorder.sv */
// Reset cause recorder: collects internal reset causes, drives system reset, keeps flags.
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "rcr_params.svh"
module rcr_reset_cause_recorder (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  input wire logic power_on_event_i,
  input wire logic brownout_event_i,
  input wire logic external_reset_pin_i,
  input wire logic watchdog_expire_i,
  input wire logic watchdog_clear_instr_i,
  input wire logic power_save_sleep_i,
  input wire logic power_save_idle_i,
  input wire logic wake_i,
  input wire logic soft_reset_instr_i,
  input wire logic trap_active_i,
  input wire logic [3:0] trap_active_level_i,
  input wire logic trap_new_i,
  input wire logic [3:0] trap_new_level_i,
  input wire logic [15:0] pin_select_i,
  input wire logic exec_valid_i,
  input wire logic [23:0] exec_word_i,
  input wire logic wreg_write_i,
  input wire logic [3:0] wreg_write_idx_i,
  input wire logic ptr_use_i,
  input wire logic [3:0] ptr_idx_i,
  input wire logic program_flow_change_i,
  input wire logic vector_flow_change_i,
  input wire logic flow_target_restricted_i,
  output logic system_reset_out_o,
  output logic cold_reset_o,
  output logic wake_cpu_o,
  output logic [1:0] cpu_mode_o,
  output logic irq_o
);
  rcr_pkg::rcr_word_t flags_r;
  rcr_pkg::rcr_word_t flags_nxt;
  rcr_pkg::rcr_word_t irq_stat_r;
  rcr_pkg::rcr_word_t irq_en_r;
  rcr_pkg::rcr_word_t shadow_r;
  rcr_pkg::rcr_mode_e mode_r;
  logic mismatch_en_r;
  logic [`RCR_NUM_WREG-1:0] winit_r;
  logic [3:0] rst_cnt_r;
  logic wd_reset, wd_wake, trap_conflict, mismatch, illegal_op, uninit_ptr;
  logic secure_hit, illegal_any, cold, warm_cause, any_cause;
  rcr_pkg::rcr_word_t hw_set, hw_clr;
  logic wr_flags;

  assign cold = power_on_event_i | brownout_event_i;
  // Watchdog expiry resets only while running; in sleep or idle it wakes.
  assign wd_reset = watchdog_expire_i && (mode_r == rcr_pkg::RCR_RUN);
  assign wd_wake = watchdog_expire_i && (mode_r != rcr_pkg::RCR_RUN);
  assign trap_conflict = trap_active_i && trap_new_i &&
    (trap_new_level_i >= `RCR_HARD_LO) && (trap_active_level_i <= `RCR_HARD_HI) &&
    (trap_new_level_i < trap_active_level_i);
  assign mismatch = mismatch_en_r && (pin_select_i != shadow_r);
  assign illegal_op = exec_valid_i && (exec_word_i[23:16] == `RCR_ILLEGAL_OP);
  assign uninit_ptr = ptr_use_i && (ptr_idx_i < 4'(`RCR_NUM_WREG)) &&
    !winit_r[ptr_idx_i];
  assign secure_hit = (program_flow_change_i | vector_flow_change_i) &&
    flow_target_restricted_i;
  assign illegal_any = illegal_op | uninit_ptr | secure_hit;
  assign warm_cause = wd_reset | trap_conflict | mismatch | illegal_any |
    soft_reset_instr_i | external_reset_pin_i;
  assign any_cause = warm_cause | cold;

  always_comb begin
    hw_set = 16'h0000;
    hw_clr = 16'h0000;
    hw_set[`RCR_BIT_WDOG] = wd_reset;
    hw_set[`RCR_BIT_TRAP] = trap_conflict;
    hw_set[`RCR_BIT_MISMATCH] = mismatch;
    hw_set[`RCR_BIT_ILLEGAL] = illegal_any;
    hw_set[`RCR_BIT_SOFT] = soft_reset_instr_i;
    hw_set[`RCR_BIT_PIN] = external_reset_pin_i;
    hw_set[`RCR_BIT_SLEEP] = power_save_sleep_i;
    hw_set[`RCR_BIT_IDLE] = power_save_idle_i;
    hw_set[`RCR_BIT_BROWN] = cold;
    hw_set[`RCR_BIT_POWER] = power_on_event_i;
    if (cold) begin
      hw_clr = `RCR_FLAGS_IMPL;
      hw_clr[`RCR_BIT_PIN] = power_on_event_i;
      // Cold events only ever set the two power bits, so a brown-out keeps the power-on bit.
      hw_clr[`RCR_BIT_BROWN] = 1'b0;
      hw_clr[`RCR_BIT_POWER] = 1'b0;
    end
    if (watchdog_clear_instr_i || power_save_sleep_i || power_save_idle_i) begin
      hw_clr[`RCR_BIT_WDOG] = 1'b1;
    end
  end

  assign wr_flags = wr_i && (addr_i == `RCR_ADDR_FLAGS);

  always_comb begin
    flags_nxt = flags_r;
    if (wr_flags) begin
      flags_nxt = wdata_i & `RCR_FLAGS_IMPL;
    end
    flags_nxt = (flags_nxt & ~hw_clr) | hw_set;
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      flags_r <= `RCR_FLAGS_RESET;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // Reset request is combinational so a watchdog expiry resets at once; a pulse stretches it.
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rst_cnt_r <= 4'h0;
    end else if (any_cause) begin
      rst_cnt_r <= `RCR_RST_PULSE;
    end else if (rst_cnt_r != 4'h0) begin
      rst_cnt_r <= rst_cnt_r - 4'h1;
    end
  end
  assign system_reset_out_o = any_cause || (rst_cnt_r != 4'h0);
  // Only power events reselect the oscillator; warm resets keep the current one.
  assign cold_reset_o = cold;

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mode_r <= rcr_pkg::RCR_RUN;
    end else if (any_cause || wake_i || wd_wake) begin
      mode_r <= rcr_pkg::RCR_RUN;
    end else if (power_save_sleep_i) begin
      mode_r <= rcr_pkg::RCR_SLEEP;
    end else if (power_save_idle_i) begin
      mode_r <= rcr_pkg::RCR_IDLE;
    end
  end
  assign cpu_mode_o = mode_r;

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wake_cpu_o <= 1'b0;
    end else begin
      wake_cpu_o <= wd_wake;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      winit_r <= '0;
    end else if (system_reset_out_o) begin
      winit_r <= '0;
    end else if (wreg_write_i && (wreg_write_idx_i < 4'(`RCR_NUM_WREG))) begin
      winit_r[wreg_write_idx_i] <= 1'b1;
    end
  end

  // Shadow copy is loaded by software; writing bit 0 of the control register arms the comparison.
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      shadow_r <= 16'h0000;
      mismatch_en_r <= 1'b0;
      irq_en_r <= 16'h0000;
    end else begin
      if (wr_i && addr_i == `RCR_ADDR_SHADOW) begin
        shadow_r <= wdata_i;
      end
      if (wr_i && addr_i == `RCR_ADDR_CTRL) begin
        mismatch_en_r <= wdata_i[0];
      end
      if (wr_i && addr_i == `RCR_ADDR_IRQ_EN) begin
        irq_en_r <= wdata_i & `RCR_FLAGS_IMPL;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_stat_r <= 16'h0000;
    end else if (wr_i && addr_i == `RCR_ADDR_IRQ_CLR) begin
      irq_stat_r <= (irq_stat_r & ~wdata_i) | hw_set;
    end else begin
      irq_stat_r <= irq_stat_r | hw_set;
    end
  end
  assign irq_o = |(irq_stat_r & irq_en_r);

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_o <= 16'h0000;
    end else if (rd_i) begin
      if (addr_i == `RCR_ADDR_FLAGS) begin
        rdata_o <= flags_r;
      end else if (addr_i == `RCR_ADDR_IRQ_STAT) begin
        rdata_o <= irq_stat_r;
      end else if (addr_i == `RCR_ADDR_IRQ_EN) begin
        rdata_o <= irq_en_r;
      end else if (addr_i == `RCR_ADDR_CTRL) begin
        rdata_o <= {15'h0000, mismatch_en_r};
      end else if (addr_i == `RCR_ADDR_SHADOW) begin
        rdata_o <= shadow_r;
      end else begin
        rdata_o <= 16'h0000;
      end
    end else begin
      rdata_o <= 16'h0000;
    end
  end

  property p_wd_flag;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      wd_reset |=> flags_r[`RCR_BIT_WDOG];
  endproperty
  a_wd_flag: assert property (p_wd_flag) else $error("watchdog flag not set");
  property p_wd_rst;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      wd_reset |-> system_reset_out_o ##1 system_reset_out_o;
  endproperty
  a_wd_rst: assert property (p_wd_rst) else $error("watchdog did not reset");
  property p_wd_wake;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (watchdog_expire_i && mode_r != rcr_pkg::RCR_RUN && !warm_cause && !cold)
      |-> (!system_reset_out_o || rst_cnt_r != 4'h0) ##1 wake_cpu_o;
  endproperty
  a_wd_wake: assert property (p_wd_wake) else $error("sleep watchdog misbehaved");
  property p_trap;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      trap_conflict |=> flags_r[`RCR_BIT_TRAP];
  endproperty
  a_trap: assert property (p_trap) else $error("trap flag not set");
  property p_mis;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      mismatch |-> system_reset_out_o ##1 flags_r[`RCR_BIT_MISMATCH];
  endproperty
  a_mis: assert property (p_mis) else $error("mismatch not handled");
  property p_ill;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (exec_valid_i && exec_word_i[23:16] == 8'h3f) |=> flags_r[`RCR_BIT_ILLEGAL];
  endproperty
  a_ill: assert property (p_ill) else $error("illegal opcode missed");
  property p_soft;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      soft_reset_instr_i |=> flags_r[`RCR_BIT_SOFT];
  endproperty
  a_soft: assert property (p_soft) else $error("soft flag not set");
  property p_cold;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (power_on_event_i && !warm_cause && !power_save_sleep_i && !power_save_idle_i) |=>
        flags_r == `RCR_FLAGS_RESET;
  endproperty
  a_cold: assert property (p_cold) else $error("power-on flags wrong");
  property p_setwin;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (wr_flags && hw_set != 16'h0000) |=> (flags_r & $past(hw_set)) == $past(hw_set);
  endproperty
  a_setwin: assert property (p_setwin) else $error("clear beat set");
  property p_sw;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (wr_flags && hw_set == 16'h0 && hw_clr == 16'h0) |=>
        flags_r == ($past(wdata_i) & 16'hc2df);
  endproperty
  a_sw: assert property (p_sw) else $error("software write lost");

  property p_wd_norst;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (wd_wake && !warm_cause && !cold && rst_cnt_r == 4'h0) |-> !system_reset_out_o;
  endproperty
  a_wd_norst: assert property (p_wd_norst) else $error("sleep watchdog reset");

  property p_trap_rst;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      trap_conflict |-> system_reset_out_o;
  endproperty
  a_trap_rst: assert property (p_trap_rst) else $error("trap conflict no reset");

  property p_mis_rst;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (mismatch_en_r && pin_select_i != shadow_r) |-> system_reset_out_o;
  endproperty
  a_mis_rst: assert property (p_mis_rst) else $error("mismatch no reset");

  property p_ill_rst;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      illegal_op |-> system_reset_out_o;
  endproperty
  a_ill_rst: assert property (p_ill_rst) else $error("illegal opcode no reset");

  property p_uninit;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      uninit_ptr |-> system_reset_out_o ##1 flags_r[`RCR_BIT_ILLEGAL];
  endproperty
  a_uninit: assert property (p_uninit) else $error("uninitialised pointer missed");

  property p_sp_safe;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (ptr_use_i && ptr_idx_i == 4'hf) |-> !uninit_ptr;
  endproperty
  a_sp_safe: assert property (p_sp_safe) else $error("stack pointer faulted");

  property p_winit_clr;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      system_reset_out_o |=> winit_r == 15'h0000;
  endproperty
  a_winit_clr: assert property (p_winit_clr) else $error("registers not cleared");

  property p_sec;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      secure_hit |-> system_reset_out_o ##1 flags_r[`RCR_BIT_ILLEGAL];
  endproperty
  a_sec: assert property (p_sec) else $error("security reset missed");

  property p_ill_flag;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      illegal_any |=> flags_r[`RCR_BIT_ILLEGAL];
  endproperty
  a_ill_flag: assert property (p_ill_flag) else $error("illegal flag not set");

  property p_cold_clr;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      cold |=> (flags_r & 16'hc25c & ~$past(hw_set)) == 16'h0000;
  endproperty
  a_cold_clr: assert property (p_cold_clr) else $error("cold event left flags");

  property p_bor_keep;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (brownout_event_i && !power_on_event_i && !external_reset_pin_i && !wr_flags) |=>
        flags_r[`RCR_BIT_PIN] == $past(flags_r[`RCR_BIT_PIN]) &&
        flags_r[`RCR_BIT_POWER] == $past(flags_r[`RCR_BIT_POWER]);
  endproperty
  a_bor_keep: assert property (p_bor_keep) else $error("brown-out cleared a kept flag");

  property p_wd_clr;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      ((watchdog_clear_instr_i || power_save_sleep_i || power_save_idle_i) && !wd_reset)
        |=> !flags_r[`RCR_BIT_WDOG];
  endproperty
  a_wd_clr: assert property (p_wd_clr) else $error("watchdog flag not cleared");

  property p_sleep_flag;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      power_save_sleep_i |=> flags_r[`RCR_BIT_SLEEP];
  endproperty
  a_sleep_flag: assert property (p_sleep_flag) else $error("sleep flag not set");

  property p_idle_flag;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      power_save_idle_i |=> flags_r[`RCR_BIT_IDLE];
  endproperty
  a_idle_flag: assert property (p_idle_flag) else $error("idle flag not set");

  property p_bor_flag;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      cold |=> flags_r[`RCR_BIT_BROWN];
  endproperty
  a_bor_flag: assert property (p_bor_flag) else $error("brown-out flag not set");

  property p_osc_keep;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (warm_cause && !cold) |-> !cold_reset_o;
  endproperty
  a_osc_keep: assert property (p_osc_keep) else $error("warm reset reselected clock");

  property p_rst_hold;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      any_cause |=> system_reset_out_o ##1 system_reset_out_o;
  endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("reset not stretched");

  c_wd: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i) wd_reset);
  c_wake: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i) wd_wake);
  c_trap: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i) trap_conflict);
  c_uninit: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i) uninit_ptr);
endmodule

/* shared/rcr_params.svh */
// Constants of the reset cause recorder: offsets, flag positions and reset values.
// Overview of operation
// - Watchdog expiry while running asserts system reset
// - Watchdog expiry in sleep/idle only wakes
// - Watchdog reset sets flag bit 4
// - Lower hard trap during higher one resets
// - Trap conflict sets flag bit 15
// - Pin-select registers mismatching shadow cause reset
// - Mismatch reset sets flag bit 9
// - Executing illegal opcode resets device
// - Upper eight bits 3Fh mean illegal opcode
// - Resets clear working registers; uninitialised pointer resets
// - Flow change into protected segment resets
// - Illegal conditions set flag bit 14
// - Power events clear flags; watchdog flag extras
// - Sleep bit3, idle bit2, brownout bit1, poweron bit0
// - Software can set or clear each flag
// - Software reset instruction sets flag bit 6
// - Warm reset keeps current oscillator source
`ifndef RCR_PARAMS_SVH
`define RCR_PARAMS_SVH
`define RCR_ADDR_FLAGS 4'h0
`define RCR_ADDR_IRQ_STAT 4'h1
`define RCR_ADDR_IRQ_CLR 4'h2
`define RCR_ADDR_IRQ_EN 4'h3
`define RCR_ADDR_CTRL 4'h4
`define RCR_ADDR_SHADOW 4'h5
`define RCR_BIT_TRAP 15
`define RCR_BIT_ILLEGAL 14
`define RCR_BIT_MISMATCH 9
`define RCR_BIT_PIN 7
`define RCR_BIT_SOFT 6
`define RCR_BIT_WDOG 4
`define RCR_BIT_SLEEP 3
`define RCR_BIT_IDLE 2
`define RCR_BIT_BROWN 1
`define RCR_BIT_POWER 0
`define RCR_FLAGS_RESET 16'h0003
`define RCR_FLAGS_IMPL 16'hc2df
`define RCR_ILLEGAL_OP 8'h3f
`define RCR_HARD_LO 4'hd
`define RCR_HARD_HI 4'hf
`define RCR_NUM_WREG 15
`define RCR_RST_PULSE 4'h2
`endif

/* shared/rcr_pkg.sv */
// Types of the reset cause recorder.
package rcr_pkg;
  typedef enum logic [1:0] {
    RCR_RUN = 2'b00,
    RCR_SLEEP = 2'b01,
    RCR_IDLE = 2'b10
  } rcr_mode_e;
  typedef logic [15:0] rcr_word_t;
endpackage

/* tb/rcr_fault_src.sv */
// Model of the on-chip fault sources: turns one coded request into its event pulse.
`timescale 1ns/1ps
module rcr_fault_src (
  input wire logic fire_i,
  input wire logic [3:0] code_i,
  input wire logic [23:0] arg_i,
  output logic [15:0] ev_o,
  output logic [3:0] lvl_act_o,
  output logic [3:0] lvl_new_o,
  output logic [23:0] word_o,
  output logic [3:0] idx_o,
  output logic restr_o
);
  // Qualifiers follow the argument at all times, so stale values are never hidden.
  always_comb begin
    ev_o = 16'h0000;
    ev_o[code_i] = fire_i;
  end
  assign lvl_act_o = arg_i[7:4];
  assign lvl_new_o = arg_i[3:0];
  assign word_o = arg_i;
  assign idx_o = arg_i[3:0];
  assign restr_o = arg_i[0];
endmodule

/* tb/rcr_reset_cause_recorder_bench.sv */
// Bench of the reset cause recorder: bus tasks, fault requests and scenarios.
`timescale 1ns/1ps
`include "rcr_params.svh"
module rcr_reset_cause_recorder_bench;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic fire = 1'b0;
  logic [3:0] code = 4'h0;
  logic [23:0] arg = 24'h000000;
  logic [15:0] pin_sel = 16'h0000;
  logic [15:0] ev, rdata;
  logic [3:0] lva, lvn, idx;
  logic [23:0] word;
  logic restr, rst_o, cold_o, wake_o, irq;
  logic [1:0] mode;
  int n_mismatch = 0;
  int n_tests = 0;
  always #4 clk_sys_i = ~clk_sys_i;
  rcr_fault_src src_u (.fire_i(fire), .code_i(code), .arg_i(arg), .ev_o(ev), .lvl_act_o(lva),
    .lvl_new_o(lvn), .word_o(word), .idx_o(idx), .restr_o(restr));
  rcr_reset_cause_recorder dut_u (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .power_on_event_i(ev[0]),
    .brownout_event_i(ev[1]), .external_reset_pin_i(ev[2]), .watchdog_expire_i(ev[3]),
    .watchdog_clear_instr_i(ev[4]), .power_save_sleep_i(ev[5]), .power_save_idle_i(ev[6]),
    .wake_i(ev[7]), .soft_reset_instr_i(ev[8]), .trap_active_i(ev[9]),
    .trap_active_level_i(lva), .trap_new_i(ev[9]), .trap_new_level_i(lvn),
    .pin_select_i(pin_sel), .exec_valid_i(ev[10]), .exec_word_i(word), .wreg_write_i(ev[11]),
    .wreg_write_idx_i(idx), .ptr_use_i(ev[12]), .ptr_idx_i(idx),
    .program_flow_change_i(ev[13]), .vector_flow_change_i(ev[14]),
    .flow_target_restricted_i(restr), .system_reset_out_o(rst_o), .cold_reset_o(cold_o),
    .wake_cpu_o(wake_o), .cpu_mode_o(mode), .irq_o(irq));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys_i);
    wr <= 1'b0;
  endtask
  task automatic bus_rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_i);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Returns reset, cold and wake as seen around one event pulse.
  task automatic fire_ev(input logic [3:0] c, input logic [23:0] a, output logic [15:0] r);
    @(posedge clk_sys_i);
    fire <= 1'b1;
    code <= c;
    arg <= a;
    #1 r = {13'h0000, rst_o, cold_o, 1'b0};
    @(posedge clk_sys_i);
    fire <= 1'b0;
    #1 r[0] = wake_o;
    repeat (4) @(posedge clk_sys_i);
  endtask
  // Reads the flags, then clears them as software should after reading.
  task automatic flags_are(input logic [15:0] exp);
    logic [15:0] d;
    bus_rd(`RCR_ADDR_FLAGS, d);
    chk(d, exp);
    bus_wr(`RCR_ADDR_FLAGS, 16'h0000);
  endtask
  task automatic cause(input logic [3:0] c, input logic [23:0] a, input logic [15:0] exp);
    logic [15:0] r;
    fire_ev(c, a, r);
    chk(r, 16'h0004);
    flags_are(exp);
  endtask
  task automatic quiet(input logic [3:0] c, input logic [23:0] a, input logic [15:0] exp);
    logic [15:0] r;
    fire_ev(c, a, r);
    chk(r, exp);
  endtask
  task automatic t_reset_values;
    logic [15:0] d;
    flags_are(`RCR_FLAGS_RESET);
    bus_rd(4'hf, d);
    chk(d, 16'h0000);
    bus_wr(`RCR_ADDR_FLAGS, 16'hffff);
    flags_are(`RCR_FLAGS_IMPL);
  endtask
  task automatic t_warm_causes;
    cause(4'h2, 24'h0, 16'h0080);
    cause(4'h3, 24'h0, 16'h0010);
    cause(4'h8, 24'h0, 16'h0040);
    cause(4'h9, 24'h0000fd, 16'h8000);
    cause(4'ha, 24'h3f1234, 16'h4000);
    cause(4'hc, 24'h000003, 16'h4000);
    cause(4'hd, 24'h000001, 16'h4000);
    cause(4'he, 24'h000001, 16'h4000);
  endtask
  task automatic t_no_fault;
    quiet(4'ha, 24'h3e1234, 16'h0);
    quiet(4'h9, 24'h0000de, 16'h0);
    quiet(4'hb, 24'h000003, 16'h0);
    quiet(4'hc, 24'h000003, 16'h0);
    quiet(4'hc, 24'h00000f, 16'h0);
    quiet(4'hd, 24'h000000, 16'h0);
    flags_are(16'h0000);
  endtask
  task automatic t_cold;
    bus_wr(`RCR_ADDR_FLAGS, 16'hffff);
    quiet(4'h1, 24'h0, 16'h0006);
    flags_are(16'h0083);
    bus_wr(`RCR_ADDR_FLAGS, 16'h0080);
    quiet(4'h0, 24'h0, 16'h0006);
    flags_are(16'h0003);
  endtask
  task automatic t_power_save;
    bus_wr(`RCR_ADDR_FLAGS, 16'h0010);
    quiet(4'h4, 24'h0, 16'h0);
    flags_are(16'h0000);
    bus_wr(`RCR_ADDR_FLAGS, 16'h0010);
    quiet(4'h5, 24'h0, 16'h0);
    chk({14'h0, mode}, {14'h0, rcr_pkg::RCR_SLEEP});
    flags_are(16'h0008);
    quiet(4'h3, 24'h0, 16'h0001);
    chk({14'h0, mode}, {14'h0, rcr_pkg::RCR_RUN});
    quiet(4'h6, 24'h0, 16'h0);
    chk({14'h0, mode}, {14'h0, rcr_pkg::RCR_IDLE});
    flags_are(16'h0004);
    quiet(4'h3, 24'h0, 16'h0001);
    chk({14'h0, mode}, {14'h0, rcr_pkg::RCR_RUN});
    quiet(4'h7, 24'h0, 16'h0);
    bus_wr(`RCR_ADDR_FLAGS, 16'h0000);
    flags_are(16'h0000);
  endtask
  task automatic t_mismatch;
    logic [15:0] d;
    bus_wr(`RCR_ADDR_SHADOW, 16'h5a5a);
    pin_sel <= 16'h5a5a;
    bus_rd(`RCR_ADDR_SHADOW, d);
    chk(d, 16'h5a5a);
    bus_wr(`RCR_ADDR_CTRL, 16'h0001);
    bus_rd(`RCR_ADDR_CTRL, d);
    chk(d, 16'h0001);
    @(posedge clk_sys_i);
    pin_sel <= 16'h5a5b;
    #1 chk({15'h0, rst_o}, 16'h0001);
    @(posedge clk_sys_i);
    pin_sel <= 16'h5a5a;
    bus_wr(`RCR_ADDR_CTRL, 16'h0000);
    repeat (4) @(posedge clk_sys_i);
    flags_are(16'h0200);
  endtask
  task automatic t_set_beats_clear;
    @(posedge clk_sys_i);
    addr <= `RCR_ADDR_FLAGS;
    wdata <= 16'h0000;
    wr <= 1'b1;
    fire <= 1'b1;
    code <= 4'h2;
    @(posedge clk_sys_i);
    wr <= 1'b0;
    fire <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    flags_are(16'h0080);
  endtask
  task automatic t_irq;
    logic [15:0] d;
    bus_wr(`RCR_ADDR_IRQ_CLR, 16'hffff);
    bus_wr(`RCR_ADDR_IRQ_EN, 16'hffff);
    #1 chk({15'h0, irq}, 16'h0000);
    bus_rd(`RCR_ADDR_IRQ_EN, d);
    chk(d, `RCR_FLAGS_IMPL);
    cause(4'h8, 24'h0, 16'h0040);
    chk({15'h0, irq}, 16'h0001);
    bus_rd(`RCR_ADDR_IRQ_STAT, d);
    chk(d, 16'h0040);
    bus_wr(`RCR_ADDR_IRQ_CLR, 16'hffff);
    #1 chk({15'h0, irq}, 16'h0000);
    bus_wr(`RCR_ADDR_IRQ_EN, 16'h0000);
    cause(4'h8, 24'h0, 16'h0040);
    chk({15'h0, irq}, 16'h0000);
  endtask
  task automatic results;
    $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    n_mismatch++;
    results;
  end
  initial begin
    repeat (6) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    t_reset_values;
    t_warm_causes;
    t_no_fault;
    t_cold;
    t_power_save;
    t_mismatch;
    t_set_beats_clear;
    t_irq;
    results;
  end
endmodule
